// ==== rtl/crc_consts.vh ====
`ifndef CRC_CONSTS_VH
`define CRC_CONSTS_VH
// Register byte addresses.
`define CRC_ADDR_CONFIG 8'h00
`define CRC_ADDR_STATUS 8'h04
`define CRC_ADDR_CAUSE 8'h08
`define CRC_ADDR_HOLD 8'h0C
`define CRC_ADDR_SCRATCH 8'h10
// Configuration word fields.
`define CRC_CFG_OSC_LSB 0
`define CRC_CFG_OSC_MSB 2
`define CRC_CFG_DOG_EN 3
`define CRC_CFG_UPDLY_DIS 4
`define CRC_CFG_MCPIN_SEL 5
`define CRC_CFG_CP_DIS 6
`define CRC_CFG_CPD_DIS 7
`define CRC_CFG_BROWN_LSB 8
`define CRC_CFG_BROWN_MSB 9
`define CRC_CFG_FSCM_EN 11
`define CRC_CFG_RESET 32'h00000FFF
`define CRC_CFG_WMASK 32'h00000BBF
// Oscillator select codes.
`define CRC_OSC_LOWPWR 3'h0
`define CRC_OSC_STDXTAL 3'h1
`define CRC_OSC_FASTXTAL 3'h2
`define CRC_OSC_EXTCLK 3'h3
`define CRC_OSC_INTIO 3'h4
`define CRC_OSC_INT 3'h5
`define CRC_OSC_RCIO 3'h6
`define CRC_OSC_RC 3'h7
// Reset cause codes.
`define CRC_CAUSE_POR 3'h0
`define CRC_CAUSE_DOG_RUN 3'h1
`define CRC_CAUSE_DOG_SLP 3'h2
`define CRC_CAUSE_PIN_RUN 3'h3
`define CRC_CAUSE_PIN_SLP 3'h4
`define CRC_CAUSE_BROWN 3'h5
`define CRC_CAUSE_DOG_WAKE 3'h6
// Timing.
`define CRC_CLK_MHZ 100
`define CRC_POR_DLY_US 1
`define CRC_POR_DLY_CYC (`CRC_POR_DLY_US * `CRC_CLK_MHZ)
`define CRC_UPDLY_MS 64
`define CRC_UPDLY_LF_HZ 31000
`define CRC_UPDLY_TICKS ((`CRC_UPDLY_MS * `CRC_UPDLY_LF_HZ + 999) / 1000)
`define CRC_FILT_CYC 8
`endif

// ==== rtl/crc_chip_reset_controller.v ====
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "crc_consts.vh"
module crc_chip_reset_controller
#(
  parameter POR_DLY_CYC = `CRC_POR_DLY_CYC,
  parameter POWER_UP_DELAY_TIMER_TICKS = `CRC_UPDLY_TICKS
)
(
  input wire clock_i,
  input wire arst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire por_ok_i,
  input wire rearm_dip_i,
  input wire bor_ok_i,
  input wire lf_tick_i,
  input wire master_clear_pin_i,
  input wire sleep_i,
  input wire wdt_timeout_i,
  input wire osc_fail_i,
  input wire bulk_erase_i,
  output reg core_rst_n_o,
  output reg reg_reset_o,
  output reg [2:0] osc_select_field_o,
  output reg osc1_xtal_o,
  output reg osc2_xtal_o,
  output reg osc2_clkout_o,
  output reg int_osc_stop_o,
  output reg master_clear_pin_pullup_o,
  output reg master_clear_pin_digital_in_o,
  output reg wdt_block_o,
  output reg data_erase_o,
  output reg cp_off_o,
  output reg timeout_status_flag_o,
  output reg powerdown_status_flag_o
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and state encodings.
localparam ST_POR = 3'h0;
localparam ST_BOR = 3'h1;
localparam ST_DLY = 3'h2;
localparam ST_POWER_UP_DELAY_TIMER = 3'h3;
localparam ST_MASTER_CLEAR_PIN = 3'h4;
localparam ST_RUN = 3'h5;

reg rst_s1_q;
reg rst_s2_q;
always @(posedge clock_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    rst_s1_q <= 1'b0;
    rst_s2_q <= 1'b0;
  end
  else
  begin
    rst_s1_q <= 1'b1;
    rst_s2_q <= rst_s1_q;
  end
end
wire rst_n = rst_s2_q;

////////////////////////////////////////////////////////////////////////////////
// Registers and bus slave.
reg [31:0] cfg_q;
reg [2:0] cause_q;
reg [31:0] hold_q;
reg [31:0] scratch_q;
reg to_q;
reg pd_q;
reg wr_pend_q;
reg [7:0] wr_addr_q;
reg [31:0] rdata_q;
reg [2:0] state_q;
reg [31:0] cnt_q;
reg [3:0] filt_cnt_q;
reg master_clear_pin_filt_q;
reg wdt_used_q;
wire [2:0] osc = cfg_q[`CRC_CFG_OSC_MSB:`CRC_CFG_OSC_LSB];
wire master_clear_pin_sel = cfg_q[`CRC_CFG_MCPIN_SEL];
wire bor_en = cfg_q[`CRC_CFG_BROWN_MSB:`CRC_CFG_BROWN_LSB] != 2'h0;
wire power_up_delay_timer_en = !cfg_q[`CRC_CFG_UPDLY_DIS];
wire xtal = osc == `CRC_OSC_LOWPWR || osc == `CRC_OSC_STDXTAL || osc == `CRC_OSC_FASTXTAL;
wire acc = hsel_i && hready_i && htrans_i[1];
wire cfg_wr = wr_pend_q && wr_addr_q == `CRC_ADDR_CONFIG;
wire master_clear_pin_act = master_clear_pin_sel && master_clear_pin_filt_q;
wire wdt_rst = wdt_timeout_i && !wdt_block_o && !sleep_i && state_q == ST_RUN;
wire wdt_wake = wdt_timeout_i && !wdt_block_o && sleep_i && state_q == ST_RUN;
wire master_clear_pin_hit = master_clear_pin_act && state_q == ST_RUN;
wire bor_hit = bor_en && !bor_ok_i && state_q == ST_RUN;
wire por_hit = !por_ok_i || rearm_dip_i;

assign hreadyout_o = 1'b1;
assign hresp_o = 1'b0;
assign hrdata_o = rdata_q;

// Writes to the configuration word cannot clear code protection.
wire [31:0] cfg_wdata = (hwdata_i & `CRC_CFG_WMASK) | (cfg_q & ~`CRC_CFG_WMASK);

always @(posedge clock_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    wr_pend_q <= 1'b0;
    wr_addr_q <= 8'h00;
    rdata_q <= 32'h00000000;
    cfg_q <= `CRC_CFG_RESET;
    scratch_q <= 32'h00000000;
    hold_q <= 32'h00000000;
  end
  else if (!rst_n)
  begin
    wr_pend_q <= 1'b0;
    rdata_q <= 32'h00000000;
  end
  else
  begin
    wr_pend_q <= acc && hwrite_i;
    wr_addr_q <= haddr_i[7:0];
    if (acc && !hwrite_i)
    begin
      case (haddr_i[7:0])
        `CRC_ADDR_CONFIG: rdata_q <= cfg_q;
        `CRC_ADDR_STATUS: rdata_q <= {24'h000000, 3'h0, master_clear_pin_filt_q, wdt_used_q, core_rst_n_o, to_q, pd_q};
        `CRC_ADDR_CAUSE: rdata_q <= {29'h00000000, cause_q};
        `CRC_ADDR_HOLD: rdata_q <= hold_q;
        `CRC_ADDR_SCRATCH: rdata_q <= scratch_q;
        default: rdata_q <= 32'h00000000;
      endcase
    end
    if (bulk_erase_i)
      cfg_q <= cfg_q | (32'h1 << `CRC_CFG_CP_DIS) | (32'h1 << `CRC_CFG_CPD_DIS);
    else if (cfg_wr)
      cfg_q <= cfg_wdata;
    if (wr_pend_q && wr_addr_q == `CRC_ADDR_HOLD)
      hold_q <= hwdata_i;
    if (reg_reset_o)
      scratch_q <= 32'h00000000;
    else if (wr_pend_q && wr_addr_q == `CRC_ADDR_SCRATCH)
      scratch_q <= hwdata_i;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Master clear noise filter: the pin level must be stable before it counts.
always @(posedge clock_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    filt_cnt_q <= 4'h0;
    master_clear_pin_filt_q <= 1'b0;
  end
  else if (!rst_n)
  begin
    filt_cnt_q <= 4'h0;
    master_clear_pin_filt_q <= 1'b0;
  end
  else if ((!master_clear_pin_i) == master_clear_pin_filt_q)
    filt_cnt_q <= 4'h0;
  else if (filt_cnt_q == `CRC_FILT_CYC - 1)
  begin
    filt_cnt_q <= 4'h0;
    master_clear_pin_filt_q <= !master_clear_pin_i;
  end
  else
    filt_cnt_q <= filt_cnt_q + 4'h1;
end

////////////////////////////////////////////////////////////////////////////////
// Reset sequencer.
always @(posedge clock_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    state_q <= ST_POR;
    cnt_q <= 32'h00000000;
    cause_q <= `CRC_CAUSE_POR;
    to_q <= 1'b1;
    pd_q <= 1'b1;
    wdt_used_q <= 1'b0;
  end
  else if (!rst_n)
  begin
    state_q <= ST_POR;
    cnt_q <= 32'h00000000;
  end
  else
  begin
    if (!osc_fail_i)
      wdt_used_q <= 1'b0;
    else if (wdt_timeout_i && cfg_q[`CRC_CFG_FSCM_EN] && xtal)
      wdt_used_q <= 1'b1;
    if (por_hit)
    begin
      state_q <= ST_POR;
      cnt_q <= 32'h00000000;
      cause_q <= `CRC_CAUSE_POR;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_POR:
        begin
          if (cnt_q >= POR_DLY_CYC - 1)
          begin
            cnt_q <= 32'h00000000;
            state_q <= ST_BOR;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        ST_BOR:
        begin
          if (!bor_en || bor_ok_i)
            state_q <= power_up_delay_timer_en ? ST_POWER_UP_DELAY_TIMER : ST_MASTER_CLEAR_PIN;
        end
        ST_POWER_UP_DELAY_TIMER:
        begin
          if (bor_en && !bor_ok_i)
          begin
            cnt_q <= 32'h00000000;
            state_q <= ST_BOR;
          end
          else if (cnt_q >= POWER_UP_DELAY_TIMER_TICKS)
          begin
            cnt_q <= 32'h00000000;
            state_q <= ST_MASTER_CLEAR_PIN;
          end
          else if (lf_tick_i)
            cnt_q <= cnt_q + 32'h1;
        end
        ST_MASTER_CLEAR_PIN:
        begin
          if (!master_clear_pin_act)
            state_q <= ST_RUN;
        end
        ST_RUN:
        begin
          if (bor_hit)
          begin
            state_q <= ST_BOR;
            cause_q <= `CRC_CAUSE_BROWN;
            to_q <= 1'b1;
            pd_q <= 1'b1;
          end
          else if (master_clear_pin_hit)
          begin
            state_q <= ST_MASTER_CLEAR_PIN;
            cause_q <= sleep_i ? `CRC_CAUSE_PIN_SLP : `CRC_CAUSE_PIN_RUN;
            if (sleep_i)
            begin
              to_q <= 1'b1;
              pd_q <= 1'b0;
            end
          end
          else if (wdt_rst)
          begin
            state_q <= ST_MASTER_CLEAR_PIN;
            cause_q <= `CRC_CAUSE_DOG_RUN;
            to_q <= 1'b0;
          end
          else if (wdt_wake)
          begin
            cause_q <= `CRC_CAUSE_DOG_WAKE;
            to_q <= 1'b0;
            pd_q <= 1'b0;
          end
        end
        default: state_q <= ST_POR;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs.
always @(posedge clock_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    core_rst_n_o <= 1'b0;
    reg_reset_o <= 1'b1;
    osc_select_field_o <= 3'h7;
    osc1_xtal_o <= 1'b0;
    osc2_xtal_o <= 1'b0;
    osc2_clkout_o <= 1'b0;
    int_osc_stop_o <= 1'b0;
    master_clear_pin_pullup_o <= 1'b0;
    master_clear_pin_digital_in_o <= 1'b0;
    wdt_block_o <= 1'b0;
    data_erase_o <= 1'b0;
    cp_off_o <= 1'b0;
    timeout_status_flag_o <= 1'b1;
    powerdown_status_flag_o <= 1'b1;
  end
  else
  begin
    core_rst_n_o <= rst_n && state_q == ST_RUN && !por_hit;
    reg_reset_o <= !rst_n || state_q != ST_RUN;
    osc_select_field_o <= osc;
    osc1_xtal_o <= xtal;
    osc2_xtal_o <= xtal;
    osc2_clkout_o <= osc == `CRC_OSC_INT || osc == `CRC_OSC_RC;
    int_osc_stop_o <= master_clear_pin_act && (osc == `CRC_OSC_INT || osc == `CRC_OSC_INTIO ||
                      osc == `CRC_OSC_RC || osc == `CRC_OSC_RCIO);
    master_clear_pin_pullup_o <= !master_clear_pin_sel;
    master_clear_pin_digital_in_o <= !master_clear_pin_sel;
    wdt_block_o <= wdt_used_q;
    data_erase_o <= rst_n && bulk_erase_i && !cfg_q[`CRC_CFG_CP_DIS];
    cp_off_o <= cfg_q[`CRC_CFG_CP_DIS];
    timeout_status_flag_o <= to_q;
    powerdown_status_flag_o <= pd_q;
  end
end

endmodule // crc_chip_reset_controller

// ==== bench/crc_board_model.sv ====
`timescale 1ns/1ps
module crc_board_model
(
  input wire clock_i,
  input wire go_i,
  input wire [7:0] low_cyc_i,
  output wire master_clear_pin_o
);
  reg [7:0] cnt_q = 8'h00;
  // The RC network pulls the pin back high as soon as the board lets go.
  assign master_clear_pin_o = (cnt_q == 8'h00);
  always @(posedge clock_i)
    cnt_q <= go_i ? low_cyc_i : cnt_q - (cnt_q != 8'h00);
endmodule // crc_board_model

// ==== bench/crc_checker.sv ====
`timescale 1ns/1ps
module crc_checker
#(
  parameter POR_DLY_CYC = 100
)
(
  input wire clock_i, arst_n_i, por_ok_i, rearm_dip_i, bor_ok_i, wdt_timeout_i, osc_fail_i,
  input wire hreadyout_o, hresp_o, core_rst_n_o, osc1_xtal_o, osc2_xtal_o,
  input wire int_osc_stop_o, master_clear_pin_pullup_o, master_clear_pin_digital_in_o, wdt_block_o,
  input wire [2:0] osc_select_field_o
);
  reg [15:0] up_q;
  reg [1:0] calm_q;
  wire calm = por_ok_i & bor_ok_i & ~rearm_dip_i & ~wdt_timeout_i;
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      {up_q, calm_q} <= 18'h00000;
    else
      {up_q, calm_q} <= {por_ok_i ? up_q + (up_q != 16'hFFFF) : 16'h0000, calm_q[0], calm};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  bus_okay_a:
    assert property (hreadyout_o && !hresp_o) else $error("bus not okay");
  por_delay_a:
    assert property (core_rst_n_o && por_ok_i |-> up_q >= POR_DLY_CYC) else $error("early release");
  supply_rst_a:
    assert property (!por_ok_i || rearm_dip_i |-> ##[1:4] !core_rst_n_o) else $error("no supply reset");
  osc_pins_a:
    assert property ($stable(osc_select_field_o) && osc_select_field_o <= 3'h3 |->
      {osc1_xtal_o, osc2_xtal_o} == (osc_select_field_o == 3'h3 ? 2'h0 : 2'h3)) else $error("bad osc pins");
  pullup_on_a:
    assert property ($stable(master_clear_pin_digital_in_o) |-> master_clear_pin_pullup_o == master_clear_pin_digital_in_o) else $error("pull-up off");
  pin_input_a:
    assert property (master_clear_pin_digital_in_o && core_rst_n_o && calm && calm_q == 2'h3 |=> core_rst_n_o)
      else $error("pin caused reset");
  osc_stop_a:
    assert property (int_osc_stop_o |-> osc_select_field_o[2] && !master_clear_pin_digital_in_o) else $error("bad osc stop");
  wdt_block_a:
    assert property (wdt_block_o |-> osc_fail_i || $past(osc_fail_i) || $past(osc_fail_i, 2))
      else $error("bad wdt block");
  stop_seen_c: cover property (int_osc_stop_o);
  block_seen_c: cover property (wdt_block_o);
  release_c: cover property ($rose(core_rst_n_o));
endmodule // crc_checker
bind crc_chip_reset_controller crc_checker #(.POR_DLY_CYC(POR_DLY_CYC)) i_crc_checker (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .por_ok_i(por_ok_i), .rearm_dip_i(rearm_dip_i), .bor_ok_i(bor_ok_i),
  .wdt_timeout_i(wdt_timeout_i), .osc_fail_i(osc_fail_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .core_rst_n_o(core_rst_n_o), .osc1_xtal_o(osc1_xtal_o), .osc2_xtal_o(osc2_xtal_o),
  .int_osc_stop_o(int_osc_stop_o), .master_clear_pin_pullup_o(master_clear_pin_pullup_o), .master_clear_pin_digital_in_o(master_clear_pin_digital_in_o),
  .wdt_block_o(wdt_block_o), .osc_select_field_o(osc_select_field_o));

// ==== bench/chip_reset_controller_bench.sv ====
`timescale 1ns/1ps
module chip_reset_controller_bench;
  localparam int POR = 20;
  logic clk = 0, arst_n = 0, por_ok = 0, dip = 0, bor_ok = 1, lf = 0, slp = 0, wdt = 0, ofail = 0, ers = 0;
  logic go = 0, hwrite = 0, pin, hro, core_n, t_o, p_d, x1, x2, stop, pu, din, cpoff;
  logic hresp, rrst, clko, wblk;
  logic [1:0] htrans = 2'h0;
  logic [2:0] osc;
  logic [7:0] lc = 8'h00;
  logic [15:0] sd = 16'h0007;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, hold_m, scr_m;
  int miscompares = 0, tests_run = 0, n;
  crc_chip_reset_controller #(.POR_DLY_CYC(POR), .POWER_UP_DELAY_TIMER_TICKS(4)) i_crc_chip_reset_controller (
    .clock_i(clk), .arst_n_i(arst_n), .hsel_i(1'h1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hro), .hrdata_o(hrdata), .hreadyout_o(hro), .hresp_o(hresp),
    .por_ok_i(por_ok), .rearm_dip_i(dip), .bor_ok_i(bor_ok), .lf_tick_i(lf), .master_clear_pin_i(pin),
    .sleep_i(slp), .wdt_timeout_i(wdt), .osc_fail_i(ofail), .bulk_erase_i(ers), .core_rst_n_o(core_n),
    .reg_reset_o(rrst), .osc_select_field_o(osc), .osc1_xtal_o(x1), .osc2_xtal_o(x2), .osc2_clkout_o(clko),
    .int_osc_stop_o(stop), .master_clear_pin_pullup_o(pu), .master_clear_pin_digital_in_o(din), .wdt_block_o(wblk), .data_erase_o(),
    .cp_off_o(cpoff), .timeout_status_flag_o(t_o), .powerdown_status_flag_o(p_d));
  crc_board_model i_crc_board_model (.clock_i(clk), .go_i(go), .low_cyc_i(lc), .master_clear_pin_o(pin));
  initial forever #5 clk = ~clk;
  always @(posedge clk) lf <= ~lf;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("%0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Waits for the bus ready (b set) or for the core reset level, never without limit.
  task automatic wt(input logic v, input bit b);
    n = 0;
    while ((b ? hro : core_n) !== v)
    begin
      @(posedge clk);
      n++;
      if (n > 3000)
      begin
        miscompares++;
        wrap_up;
      end
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    wt(1, 1);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    wt(1, 1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 0, 0);
    chk(r, e);
  endtask
  task automatic pulse(input logic [7:0] k);
    go <= 1;
    lc <= k;
    @(posedge clk);
    go <= 0;
  endtask
  task automatic kick;
    wdt <= 1;
    @(posedge clk);
    wdt <= 0;
  endtask
  task automatic arm;
    sd = lfsr(sd);
    scr_m = {~sd, sd};
    bus(8'h10, 1, scr_m);
  endtask
  task automatic post(input int c);
    if (c != 6) scr_m = 0;
    rd(8'h08, c);
    rd(8'h0C, hold_m);
    rd(8'h10, scr_m);
    $display("cause %0d test done", c);
  endtask
  initial
  begin
    tick(5);
    arst_n <= 1;
    tick(4);
    por_ok <= 1;
    wt(1, 0);
    chk(n >= POR, 1);
    chk({t_o, p_d}, 2'h3);
    rd(8'h00, 32'h00000FFF);
    rd(8'h20, 0);
    rd(8'h08, 0);
    sd = lfsr(sd);
    hold_m = {sd, ~sd};
    bus(8'h0C, 1, hold_m);
    $display("power-on test done");
    arm;
    pulse(4);
    tick(12);
    chk(core_n, 1);
    pulse(20);
    tick(12);
    chk(stop, 1);
    wt(1, 0);
    post(3);
    chk({t_o, p_d}, 2'h3);
    arm;
    kick;
    wt(0, 0);
    chk(rrst, 1);
    chk(pin, 1);
    wt(1, 0);
    post(1);
    chk(t_o, 0);
    arm;
    slp <= 1;
    kick;
    tick(10);
    chk(core_n, 1);
    chk(rrst, 0);
    slp <= 0;
    tick(2);
    post(6);
    chk({t_o, p_d}, 2'h0);
    arm;
    bor_ok <= 0;
    tick(10);
    chk(core_n, 0);
    bor_ok <= 1;
    wt(1, 0);
    post(5);
    chk({t_o, p_d}, 2'h3);
    dip <= 1;
    por_ok <= 0;
    tick(4);
    dip <= 0;
    tick(6);
    chk(core_n, 0);
    por_ok <= 1;
    wt(1, 0);
    chk(n >= POR, 1);
    rd(8'h08, 0);
    $display("re-arm test done");
    for (int i = 0; i < 4; i++)
    begin
      bus(8'h00, 1, 32'h00000FF8 | i);
      tick(3);
      chk({osc, x1, x2}, {i[2:0], (i == 3) ? 2'h0 : 2'h3});
    end
    ers <= 1;
    @(posedge clk);
    ers <= 0;
    tick(3);
    chk(cpoff, 1);
    bus(8'h00, 1, 32'h00000FBF);
    tick(3);
    chk(cpoff, 1);
    bus(8'h00, 1, 32'h00000FDF);
    tick(3);
    chk({pu, din}, 2'h3);
    chk(clko, 1);
    pulse(20);
    tick(24);
    chk(core_n, 1);
    bus(8'h00, 1, 32'h00000FFA);
    ofail <= 1;
    kick;
    wt(0, 0);
    wt(1, 0);
    chk(wblk, 1);
    kick;
    repeat (4)
    begin
      @(posedge clk);
      chk(core_n, 1);
    end
    ofail <= 0;
    tick(3);
    chk(wblk, 0);
    chk(hresp, 0);
    $display("option test done");
    wrap_up;
  end
endmodule // chip_reset_controller_bench
